// file: src/stx_pkg.sv
// Overview of operation
// - The null-byte skip reads the addressed byte, writes the same value back, and skips the next instruction when it is zero.
// - A met skip turns the next instruction into a dummy cycle, so the skipping instruction takes four cycles instead of three.
// - The copy-and-skip variant loads the byte into the work register and skips when the byte is zero.
// - The bit skip tests the selected bit of the byte and skips only when that bit is zero.
// - The paged table fetch addresses program memory with pointer upper and lower, stores the low byte to memory and the high part to the table-high latch.
// - The final-page table fetch addresses the last page with the pointer lower only, with the same stores.
// - The pre-increment fetches first increment the pointer lower and then fetch with the new pointer.
// - The exclusive-or to work writes work xor byte into the work register and updates only the zero flag.
// - The exclusive-or to memory writes work xor byte into the data byte and updates only the zero flag.
package stx_pkg;
  localparam int STX_DATA_W = 8;
  localparam int STX_ADDR_W = 9;
  localparam int STX_PROG_AW = 13;
  localparam int STX_PROG_DW = 16;
  localparam int STX_SKIP_CYCLES = 3;
  localparam logic [7:0] STX_WORK_RST = 8'h00;
  localparam logic [7:0] STX_PTR_RST = 8'h00;
  localparam logic [7:0] STX_LATCH_RST = 8'h00;

  typedef enum logic [3:0] {
    STX_OP_NONE = 4'h0,
    STX_OP_SKIP_NULL = 4'h1,
    STX_OP_COPY_SKIP = 4'h2,
    STX_OP_SKIP_BIT = 4'h3,
    STX_OP_TAB_PAGED = 4'h4,
    STX_OP_TAB_FINAL = 4'h5,
    STX_OP_ITAB_PAGED = 4'h6,
    STX_OP_ITAB_FINAL = 4'h7,
    STX_OP_XOR_WORK = 4'h8,
    STX_OP_XOR_MEM = 4'h9
  } stx_op_e;

  typedef enum logic [2:0] {
    STX_ST_IDLE = 3'b000,
    STX_ST_READ = 3'b001,
    STX_ST_EXEC = 3'b010,
    STX_ST_TFETCH = 3'b011,
    STX_ST_DUMMY = 3'b100
  } stx_state_e;
endpackage

// file: src/stx_mem_if.sv
`timescale 1ns/1ps
interface stx_mem_if;
  import stx_pkg::*;
  logic rd_en;
  logic wr_en;
  logic [STX_ADDR_W-1:0] addr;
  logic [STX_DATA_W-1:0] wdata;
  logic [STX_DATA_W-1:0] rdata;
  modport core (output rd_en, output wr_en, output addr, output wdata, input rdata);
  modport mem (input rd_en, input wr_en, input addr, input wdata, output rdata);
endinterface

// file: src/stx_data_mem.sv
`timescale 1ns/1ps
module stx_data_mem
  import stx_pkg::*;
#(
  parameter int DEPTH = 512
) (
  input wire logic clk_sys_in,
  stx_mem_if.mem port
);
  logic [STX_DATA_W-1:0] mem_r [DEPTH];
  logic [STX_DATA_W-1:0] rdata_r;

  // Registered read, write-first not needed
  always_ff @(posedge clk_sys_in) begin
    if (port.wr_en) begin
      mem_r[port.addr] <= port.wdata;
    end
    if (port.rd_en) begin
      rdata_r <= mem_r[port.addr];
    end
  end

  assign port.rdata = rdata_r;
endmodule

// file: src/stx_exec.sv
`timescale 1ns/1ps
module stx_exec
  import stx_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys_in,
  input wire logic rst_in,
  // Instruction issue
  input wire logic issue_in,
  input wire stx_pkg::stx_op_e op_in,
  input wire logic [stx_pkg::STX_ADDR_W-1:0] addr_in,
  input wire logic [2:0] bit_sel_in,
  // Pointer preset
  input wire logic ptr_load_in,
  input wire logic [7:0] ptr_upper_in,
  input wire logic [7:0] ptr_lower_in,
  // Program memory table port
  output logic prog_rd_out,
  output logic [stx_pkg::STX_PROG_AW-1:0] prog_addr_out,
  input wire logic [stx_pkg::STX_PROG_DW-1:0] prog_data_in,
  // Core status
  output logic busy_out,
  output logic done_out,
  output logic skip_out,
  output logic zero_flag_out,
  output logic [7:0] work_register_out,
  output logic [7:0] table_high_latch_out,
  output logic [7:0] table_pointer_lower_out
);
  import stx_pkg::*;

  typedef struct packed {
    stx_state_e st;
    stx_op_e op;
    logic [STX_ADDR_W-1:0] addr;
    logic [2:0] bsel;
    logic [7:0] work;
    logic [7:0] ptr_hi;
    logic [7:0] ptr_lo;
    logic [7:0] tlatch;
    logic zf;
    logic prd;
    logic [STX_PROG_AW-1:0] paddr;
    logic busy;
    logic done;
    logic skip;
    logic mrd;
    logic mwr;
    logic [STX_ADDR_W-1:0] maddr;
    logic [STX_DATA_W-1:0] mwdata;
  } stx_state_s;

  stx_state_s s_r;
  stx_state_s s_nxt;
  stx_mem_if mif ();

  stx_data_mem u_mem (
    .clk_sys_in(clk_sys_in),
    .port(mif.mem)
  );

  assign mif.rd_en = s_r.mrd;
  assign mif.wr_en = s_r.mwr;
  assign mif.addr = s_r.maddr;
  assign mif.wdata = s_r.mwdata;

  logic [7:0] byte_v;
  logic [7:0] xor_v;
  logic is_null;
  assign byte_v = mif.rdata;
  assign xor_v = s_r.work ^ byte_v;
  assign is_null = (byte_v == 8'h00);

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    s_nxt.mrd = 1'b0;
    s_nxt.mwr = 1'b0;
    s_nxt.prd = 1'b0;
    unique case (s_r.st)
      STX_ST_IDLE: begin
        s_nxt.skip = 1'b0;
        if (ptr_load_in) begin
          s_nxt.ptr_hi = ptr_upper_in;
          s_nxt.ptr_lo = ptr_lower_in;
        end
        if (issue_in && op_in != STX_OP_NONE) begin
          s_nxt.op = op_in;
          s_nxt.addr = addr_in;
          s_nxt.bsel = bit_sel_in;
          s_nxt.busy = 1'b1;
          s_nxt.maddr = addr_in;
          if (op_in inside {STX_OP_TAB_PAGED, STX_OP_TAB_FINAL, STX_OP_ITAB_PAGED, STX_OP_ITAB_FINAL}) begin
            s_nxt.st = STX_ST_TFETCH;
            if (op_in inside {STX_OP_ITAB_PAGED, STX_OP_ITAB_FINAL}) begin
              s_nxt.ptr_lo = s_nxt.ptr_lo + 8'h01;
            end
            s_nxt.prd = 1'b1;
            if (op_in inside {STX_OP_TAB_PAGED, STX_OP_ITAB_PAGED}) begin
              s_nxt.paddr = STX_PROG_AW'({s_nxt.ptr_hi, s_nxt.ptr_lo});
            end else begin
              s_nxt.paddr = {{(STX_PROG_AW-8){1'b1}}, s_nxt.ptr_lo};
            end
          end else begin
            s_nxt.st = STX_ST_READ;
            s_nxt.mrd = 1'b1;
          end
        end
      end
      STX_ST_READ: begin
        s_nxt.st = STX_ST_EXEC;
      end
      STX_ST_EXEC: begin
        s_nxt.st = STX_ST_IDLE;
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
        unique case (s_r.op)
          STX_OP_SKIP_NULL: begin
            s_nxt.mwr = 1'b1;
            s_nxt.mwdata = byte_v;
            s_nxt.skip = is_null;
          end
          STX_OP_COPY_SKIP: begin
            s_nxt.work = byte_v;
            s_nxt.skip = is_null;
          end
          STX_OP_SKIP_BIT: begin
            s_nxt.skip = ~byte_v[s_r.bsel];
          end
          STX_OP_XOR_WORK: begin
            s_nxt.work = xor_v;
            s_nxt.zf = (xor_v == 8'h00);
          end
          STX_OP_XOR_MEM: begin
            s_nxt.mwr = 1'b1;
            s_nxt.mwdata = xor_v;
            s_nxt.zf = (xor_v == 8'h00);
          end
          default: begin
            s_nxt.skip = 1'b0;
          end
        endcase
        if (s_nxt.skip) begin
          s_nxt.st = STX_ST_DUMMY;
          s_nxt.busy = 1'b1;
          s_nxt.done = 1'b0;
        end
      end
      STX_ST_TFETCH: begin
        s_nxt.mwr = 1'b1;
        s_nxt.mwdata = prog_data_in[7:0];
        s_nxt.tlatch = prog_data_in[15:8];
        s_nxt.st = STX_ST_IDLE;
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
      STX_ST_DUMMY: begin
        s_nxt.st = STX_ST_IDLE;
        s_nxt.busy = 1'b0;
        s_nxt.done = 1'b1;
      end
      default: begin
        s_nxt.st = STX_ST_IDLE;
        s_nxt.busy = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys_in or posedge rst_in) begin
    if (rst_in) begin
      s_r <= '{st: STX_ST_IDLE, op: STX_OP_NONE, work: STX_WORK_RST, ptr_hi: STX_PTR_RST,
               ptr_lo: STX_PTR_RST, tlatch: STX_LATCH_RST, default: '0};
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prog_rd_out = s_r.prd;
  assign prog_addr_out = s_r.paddr;
  assign busy_out = s_r.busy;
  assign done_out = s_r.done;
  assign skip_out = s_r.skip;
  assign zero_flag_out = s_r.zf;
  assign work_register_out = s_r.work;
  assign table_high_latch_out = s_r.tlatch;
  assign table_pointer_lower_out = s_r.ptr_lo;

  property p_skip_null_wb;
    @(posedge clk_sys_in) disable iff (rst_in)
    (s_r.st == STX_ST_EXEC && s_r.op == STX_OP_SKIP_NULL) |=> (s_r.mwr && s_r.mwdata == $past(byte_v));
  endproperty
  a_skip_null_wb: assert property (p_skip_null_wb) else $error("write-back value wrong");

  property p_skip_three;
    @(posedge clk_sys_in) disable iff (rst_in)
    (s_r.st == STX_ST_EXEC && s_nxt.skip) |=> (s_r.st == STX_ST_DUMMY && !s_r.done) ##1 (s_r.done && s_r.skip);
  endproperty
  a_skip_three: assert property (p_skip_three) else $error("skip not three cycles");

  property p_copy;
    @(posedge clk_sys_in) disable iff (rst_in)
    (s_r.st == STX_ST_EXEC && s_r.op == STX_OP_COPY_SKIP) |=> (s_r.work == $past(byte_v)) && (s_r.skip == $past(is_null));
  endproperty
  a_copy: assert property (p_copy) else $error("copy-and-skip wrong");

  property p_bit;
    @(posedge clk_sys_in) disable iff (rst_in)
    (s_r.st == STX_ST_EXEC && s_r.op == STX_OP_SKIP_BIT) |=> (s_r.skip == !$past(byte_v[s_r.bsel]));
  endproperty
  a_bit: assert property (p_bit) else $error("bit skip wrong");

  property p_tab_paged;
    @(posedge clk_sys_in) disable iff (rst_in)
    (s_r.st == STX_ST_TFETCH && s_r.op == STX_OP_TAB_PAGED) |->
      (s_r.paddr == STX_PROG_AW'({s_r.ptr_hi, s_r.ptr_lo})) ##1 (s_r.tlatch == $past(prog_data_in[15:8]));
  endproperty
  a_tab_paged: assert property (p_tab_paged) else $error("paged fetch wrong");

  property p_tab_final;
    @(posedge clk_sys_in) disable iff (rst_in)
    (s_r.st == STX_ST_TFETCH && s_r.op == STX_OP_TAB_FINAL) |->
      (s_r.paddr[STX_PROG_AW-1:8] == '1 && s_r.paddr[7:0] == s_r.ptr_lo) ##1 (s_r.mwdata == $past(prog_data_in[7:0]));
  endproperty
  a_tab_final: assert property (p_tab_final) else $error("final-page fetch wrong");

  property p_preinc;
    @(posedge clk_sys_in) disable iff (rst_in)
    (s_r.st == STX_ST_IDLE && issue_in && op_in inside {STX_OP_ITAB_PAGED, STX_OP_ITAB_FINAL} && !ptr_load_in)
      |=> (s_r.ptr_lo == $past(s_r.ptr_lo) + 8'h01) && (s_r.paddr[7:0] == s_r.ptr_lo);
  endproperty
  a_preinc: assert property (p_preinc) else $error("pointer not pre-incremented");

  property p_xor_work;
    @(posedge clk_sys_in) disable iff (rst_in)
    (s_r.st == STX_ST_EXEC && s_r.op == STX_OP_XOR_WORK) |=> (s_r.work == $past(xor_v)) && (s_r.zf == (s_r.work == 8'h00));
  endproperty
  a_xor_work: assert property (p_xor_work) else $error("xor to work wrong");

  property p_xor_mem;
    @(posedge clk_sys_in) disable iff (rst_in)
    (s_r.st == STX_ST_EXEC && s_r.op == STX_OP_XOR_MEM) |=> s_r.mwr && (s_r.mwdata == $past(xor_v)) && $stable(s_r.work)
      && (s_r.zf == (s_r.mwdata == 8'h00));
  endproperty
  a_xor_mem: assert property (p_xor_mem) else $error("xor to memory wrong");

  property p_flags_kept;
    @(posedge clk_sys_in) disable iff (rst_in)
    (s_r.st inside {STX_ST_TFETCH, STX_ST_DUMMY} ||
     (s_r.st == STX_ST_EXEC && s_r.op inside {STX_OP_SKIP_NULL, STX_OP_COPY_SKIP, STX_OP_SKIP_BIT})) |=> $stable(s_r.zf);
  endproperty
  a_flags_kept: assert property (p_flags_kept) else $error("flag changed by skip or table op");
endmodule

// file: bench/stx_exec_tb.sv
`timescale 1ns/1ps
module stx_exec_tb;
  import stx_pkg::*;
  typedef struct {logic [7:0] work; logic [7:0] latch; logic [7:0] plo; logic zf; logic skip; int cyc;} stx_note_s;
  logic clk_sys_in = 1'b0;
  logic rst_in = 1'b1;
  logic issue_in = 1'b0;
  stx_op_e op_in = STX_OP_NONE;
  logic [STX_ADDR_W-1:0] addr_in = '0;
  logic [2:0] bit_sel_in = 3'h0;
  logic ptr_load_in = 1'b0;
  logic [7:0] ptr_upper_in = 8'h00;
  logic [7:0] ptr_lower_in = 8'h00;
  logic prog_rd_out, busy_out, done_out, skip_out, zero_flag_out;
  logic [STX_PROG_AW-1:0] prog_addr_out;
  logic [STX_PROG_DW-1:0] prog_data_in;
  logic [7:0] work_register_out, table_high_latch_out, table_pointer_lower_out;
  logic [15:0] mask = 16'h0000;
  int seed = 32'h49e90658;
  int n_errors = 0;
  int num_checks = 0;
  int cnt = 0;
  stx_note_s note_q[$];
  logic [12:0] paddr_q[$];
  logic [7:0] mem_m [4];
  logic [STX_ADDR_W-1:0] addr_t [4];
  logic [7:0] work_m = 8'h00;
  logic [7:0] latch_m = 8'h00;
  logic [7:0] plo_m = 8'h00;
  logic [7:0] pup_m = 8'h00;
  logic zf_m = 1'b0;

  // Program word depends on address, so a wrong address shows in the data
  assign prog_data_in = {3'h0, prog_addr_out} ^ mask;

  stx_exec i_dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .issue_in(issue_in), .op_in(op_in),
    .addr_in(addr_in), .bit_sel_in(bit_sel_in), .ptr_load_in(ptr_load_in), .ptr_upper_in(ptr_upper_in),
    .ptr_lower_in(ptr_lower_in), .prog_rd_out(prog_rd_out), .prog_addr_out(prog_addr_out),
    .prog_data_in(prog_data_in), .busy_out(busy_out), .done_out(done_out), .skip_out(skip_out),
    .zero_flag_out(zero_flag_out), .work_register_out(work_register_out),
    .table_high_latch_out(table_high_latch_out), .table_pointer_lower_out(table_pointer_lower_out));

  initial begin
    forever #2.5 clk_sys_in = ~clk_sys_in;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic end_sim();
    $display("Checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic wait_idle();
    for (int i = 0; i < 20 && busy_out !== 1'b0; i++) begin
      @(negedge clk_sys_in);
    end
    if (busy_out !== 1'b0) begin
      n_errors++;
      end_sim();
    end
  endtask

  task automatic load_ptr(input logic [7:0] up, input logic [7:0] lo);
    wait_idle();
    ptr_load_in = 1'b1;
    ptr_upper_in = up;
    ptr_lower_in = lo;
    pup_m = up;
    plo_m = lo;
    @(negedge clk_sys_in);
    ptr_load_in = 1'b0;
  endtask

  task automatic run(input stx_op_e op, input int k, input logic [2:0] b, input logic [15:0] mk);
    stx_note_s n;
    logic [7:0] d;
    logic [12:0] pa;
    wait_idle();
    mask = mk;
    d = mem_m[k];
    n.skip = 1'b0;
    n.cyc = 3;
    case (op)
      STX_OP_SKIP_NULL: n.skip = (d == 8'h00);
      STX_OP_COPY_SKIP: begin
        work_m = d;
        n.skip = (d == 8'h00);
      end
      STX_OP_SKIP_BIT: n.skip = ~d[b];
      STX_OP_XOR_WORK: begin
        work_m = work_m ^ d;
        zf_m = (work_m == 8'h00);
      end
      STX_OP_XOR_MEM: begin
        mem_m[k] = work_m ^ d;
        zf_m = (mem_m[k] == 8'h00);
      end
      default: begin
        if (op == STX_OP_ITAB_PAGED || op == STX_OP_ITAB_FINAL) begin
          plo_m = plo_m + 8'h01;
        end
        pa = (op == STX_OP_TAB_FINAL || op == STX_OP_ITAB_FINAL) ? {5'h1F, plo_m} : {pup_m[4:0], plo_m};
        paddr_q.push_back(pa);
        {latch_m, mem_m[k]} = {3'h0, pa} ^ mk;
        n.cyc = 2;
      end
    endcase
    n.cyc = n.cyc + int'(n.skip);
    n.work = work_m;
    n.latch = latch_m;
    n.plo = plo_m;
    n.zf = zf_m;
    note_q.push_back(n);
    op_in = op;
    addr_in = addr_t[k];
    bit_sel_in = b;
    issue_in = 1'b1;
    @(negedge clk_sys_in);
    issue_in = 1'b0;
  endtask

  // Result monitor, sampled after the bench's falling edge updates
  always @(negedge clk_sys_in) begin
    stx_note_s n;
    #1;
    cnt++;
    if (prog_rd_out === 1'b1) begin
      if (paddr_q.size() == 0) begin
        check("prog_rd_out", 16'h1, 16'h0);
      end else begin
        check("prog_addr_out", {3'h0, prog_addr_out}, {3'h0, paddr_q.pop_front()});
      end
    end
    if (done_out === 1'b1) begin
      if (note_q.size() == 0) begin
        check("done_out", 16'h1, 16'h0);
      end else begin
        n = note_q.pop_front();
        check("cycles", 16'(cnt), 16'(n.cyc));
        check("work", {8'h00, work_register_out}, {8'h00, n.work});
        check("latch", {8'h00, table_high_latch_out}, {8'h00, n.latch});
        check("ptr_lower", {8'h00, table_pointer_lower_out}, {8'h00, n.plo});
        check("zero_flag", {15'h0, zero_flag_out}, {15'h0, n.zf});
        check("skip", {15'h0, skip_out}, {15'h0, n.skip});
      end
    end
    if (issue_in === 1'b1 && busy_out === 1'b0 && rst_in === 1'b0) begin
      cnt = 0;
    end
  end

  initial begin
    int r;
    for (int i = 0; i < 4; i++) begin
      addr_t[i] = {i[1:0], 7'($random(seed))};
    end
    repeat (3) @(negedge clk_sys_in);
    check("rst_regs", {work_register_out, table_high_latch_out}, 16'h0000);
    check("rst_flags", {table_pointer_lower_out, 3'h0, busy_out, done_out, skip_out, zero_flag_out, prog_rd_out},
      16'h0000);
    rst_in = 1'b0;
    load_ptr(8'($random(seed)), 8'hFF);
    // Byte 0 forced to zero, then pointer lower wraps
    run(STX_OP_TAB_PAGED, 0, 3'h0, {8'($random(seed)), 8'hFF});
    run(STX_OP_ITAB_PAGED, 1, 3'h0, 16'($random(seed)));
    run(STX_OP_TAB_FINAL, 2, 3'h0, 16'($random(seed)));
    run(STX_OP_ITAB_FINAL, 3, 3'h0, 16'($random(seed)));
    run(STX_OP_SKIP_NULL, 0, 3'h0, 16'h0000);
    run(STX_OP_COPY_SKIP, 0, 3'h0, 16'h0000);
    for (int i = 0; i < 120; i++) begin
      r = $random(seed);
      if (r[20:18] == 3'h0) begin
        load_ptr(r[31:24], r[23:16]);
      end
      run(stx_op_e'(4'((r[15:8] % 9) + 1)), int'(r[1:0]), r[4:2], 16'($random(seed)));
    end
    wait_idle();
    repeat (3) @(negedge clk_sys_in);
    check("pending", 16'(note_q.size() + paddr_q.size()), 16'h0000);
    end_sim();
  end
endmodule
